// ### src/link_irq_pkg.sv
package link_irq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the APB
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_ENG_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h210;

   ////////////////////////////////////////////////////////////////////////////
   // Action selector fields of link_event_irq_control
   localparam int NUM_EVT = 3;
   localparam int ACT_W = 3;
   localparam int FLD_BD_LSB = 9;
   localparam int FLD_CU_LSB = 12;
   localparam int FLD_CD_LSB = 15;
   localparam int FLD_ACT_LSB = FLD_BD_LSB;
   localparam int FLD_ACT_MSB = FLD_CD_LSB + ACT_W - 1;
   localparam int EVT_BD = 0;
   localparam int EVT_CU = 1;
   localparam int EVT_CD = 2;

   // Action codes; 3'h6 and 3'h7 are reserved and act as masked
   localparam logic [ACT_W-1:0] ACT_OFF = 3'h0;
   localparam logic [ACT_W-1:0] ACT_MSI = 3'h1;
   localparam logic [ACT_W-1:0] ACT_INTA = 3'h2;
   localparam logic [ACT_W-1:0] ACT_INTD = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Legacy virtual wires and block event status
   localparam int NUM_PIN = 4;
   localparam int NUM_IEV = 4;
   localparam int IEV_MSI_SENT = 0;
   localparam int IEV_INTX_ASSERT = 1;
   localparam int IEV_INTX_NEGATE = 2;
   localparam int IEV_MSI_DROP = 3;

   // Engine status word layout
   localparam int ENG_STS_LSB = 0;
   localparam int ENG_PEND_LSB = 3;
   localparam int ENG_SENT_LSB = 6;
   localparam int ENG_MSI_REQ_BIT = 10;
   localparam int ENG_INTX_REQ_BIT = 11;

   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// ### src/link_event_irq_action_select.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module link_event_irq_action_select
   import link_irq_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [NUM_EVT-1:0] EVT_STATUS_I,
   input wire logic MSI_ENABLE_I,
   input wire logic LEGACY_IRQ_DISABLE_I,
   output logic MSI_REQ_O,
   output logic [1:0] MSI_SRC_O,
   input wire logic MSI_ACK_I,
   output logic INTX_REQ_O,
   output logic INTX_ASSERT_O,
   output logic [1:0] INTX_PIN_O,
   input wire logic INTX_ACK_I,
   output logic IRQ_O
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [NUM_EVT-1:0][ACT_W-1:0] act;
      logic [NUM_EVT-1:0] sts_prev;
      logic [NUM_EVT-1:0] msi_pend;
      logic msi_req;
      logic [1:0] msi_src;
      logic [NUM_PIN-1:0] intx_sent;
      logic intx_req;
      logic intx_assert;
      logic [1:0] intx_pin;
      logic [NUM_IEV-1:0] evt_stat;
      logic [NUM_IEV-1:0] evt_mask;
      logic irq;
      logic [31:0] rdata;
      logic slverr;
   } state_t;

   localparam state_t STATE_RST = '0;

   state_t q;
   state_t d;

   logic [NUM_EVT-1:0] rise;
   logic [NUM_PIN-1:0] want;
   logic [NUM_PIN-1:0][NUM_EVT-1:0] hit;
   logic apb_setup;
   logic apb_write;
   logic [31:0] rd_val;
   logic rd_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Per-event edges and per-pin wire levels

   // Status arrives from the status register on this clock, no sync needed
   assign rise = EVT_STATUS_I & ~q.sts_prev;

   // A virtual wire is high while any routed event's status stays set
   for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
      for (genvar e = 0; e < NUM_EVT; e++) begin : g_evt
         assign hit[p][e] = EVT_STATUS_I[e] &&
            (q.act[e] == ACT_INTA + ACT_W'(p));
      end
      assign want[p] = |hit[p];
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   assign apb_setup = PSEL_I && !PENABLE_I;
   // Zero wait states: every access phase completes on its first edge
   assign apb_write = PSEL_I && PENABLE_I && PWRITE_I;

   always_comb begin
      rd_val = RDATA_ZERO;
      rd_ok = 1'b1;
      unique case (PADDR_I)
         ADDR_CTRL: begin
            rd_val[FLD_ACT_MSB:FLD_ACT_LSB] = q.act;
         end
         ADDR_EVT_STAT: begin
            rd_val[NUM_IEV-1:0] = q.evt_stat;
         end
         ADDR_EVT_MASK: begin
            rd_val[NUM_IEV-1:0] = q.evt_mask;
         end
         ADDR_ENG_STAT: begin
            rd_val[ENG_STS_LSB +: NUM_EVT] = q.sts_prev;
            rd_val[ENG_PEND_LSB +: NUM_EVT] = q.msi_pend;
            rd_val[ENG_SENT_LSB +: NUM_PIN] = q.intx_sent;
            rd_val[ENG_MSI_REQ_BIT] = q.msi_req;
            rd_val[ENG_INTX_REQ_BIT] = q.intx_req;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      d.sts_prev = EVT_STATUS_I;

      // Read data is captured in the setup cycle so it comes from a flop
      if (apb_setup) begin
         d.rdata = rd_val;
         d.slverr = !rd_ok;
      end

      // Register writes; the clear of status goes first so a set wins
      if (apb_write) begin
         unique case (PADDR_I)
            ADDR_CTRL: begin
               d.act = PWDATA_I[FLD_ACT_MSB:FLD_ACT_LSB];
            end
            ADDR_EVT_STAT: begin
               d.evt_stat = q.evt_stat & ~PWDATA_I[NUM_IEV-1:0];
            end
            ADDR_EVT_MASK: begin
               d.evt_mask = PWDATA_I[NUM_IEV-1:0];
            end
            default: begin
            end
         endcase
      end

      // New status edges routed to MSI become pending, or are dropped
      for (int e = 0; e < NUM_EVT; e++) begin
         if (rise[e] && q.act[e] == ACT_MSI) begin
            if (MSI_ENABLE_I) begin
               d.msi_pend[e] = 1'b1;
            end else begin
               d.evt_stat[IEV_MSI_DROP] = 1'b1;
            end
         end
      end

      // Pending MSIs are lost if the capability is disabled meanwhile
      if (!MSI_ENABLE_I) begin
         if (|d.msi_pend) begin
            d.evt_stat[IEV_MSI_DROP] = 1'b1;
         end
         d.msi_pend = '0;
      end

      // MSI request: held until acknowledged, lowest event first
      if (q.msi_req) begin
         if (MSI_ACK_I) begin
            d.msi_req = 1'b0;
            d.evt_stat[IEV_MSI_SENT] = 1'b1;
         end
      end else if (MSI_ENABLE_I && |q.msi_pend) begin
         for (int e = NUM_EVT - 1; e >= 0; e--) begin
            if (q.msi_pend[e]) begin
               d.msi_src = 2'(e);
            end
         end
         d.msi_req = 1'b1;
         d.msi_pend[d.msi_src] = 1'b0;
      end

      // Legacy messages follow the wire level; a wire is only marked
      // sent once the message is taken, so nothing is lost on a stall
      if (q.intx_req) begin
         if (INTX_ACK_I) begin
            d.intx_req = 1'b0;
            d.intx_sent[q.intx_pin] = q.intx_assert;
            if (q.intx_assert) begin
               d.evt_stat[IEV_INTX_ASSERT] = 1'b1;
            end else begin
               d.evt_stat[IEV_INTX_NEGATE] = 1'b1;
            end
         end
      end else if (!LEGACY_IRQ_DISABLE_I &&
                   (want != q.intx_sent)) begin
         for (int p = NUM_PIN - 1; p >= 0; p--) begin
            if (want[p] != q.intx_sent[p]) begin
               d.intx_pin = 2'(p);
            end
         end
         d.intx_req = 1'b1;
         d.intx_assert = want[d.intx_pin];
      end

      d.irq = |(d.evt_stat & d.evt_mask);
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign PRDATA_O = q.rdata;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = q.slverr;
   assign MSI_REQ_O = q.msi_req;
   assign MSI_SRC_O = q.msi_src;
   assign INTX_REQ_O = q.intx_req;
   assign INTX_ASSERT_O = q.intx_assert;
   assign INTX_PIN_O = q.intx_pin;
   assign IRQ_O = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_ctrl_bd_write: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      apb_write && PADDR_I == ADDR_CTRL
      |=> q.act[EVT_BD] == $past(PWDATA_I[FLD_BD_LSB +: ACT_W]))
      else $error("port B down selector not written");

   a_ctrl_cu_write: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      apb_write && PADDR_I == ADDR_CTRL
      |=> q.act[EVT_CU] == $past(PWDATA_I[FLD_CU_LSB +: ACT_W]))
      else $error("port C up selector not written");

   // Write, one idle cycle, then a read of the same word
   a_ctrl_readback: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      apb_write && PADDR_I == ADDR_CTRL
      ##2 apb_setup && PADDR_I == ADDR_CTRL
      |=> PRDATA_O[FLD_ACT_MSB:FLD_ACT_LSB]
      == $past(PWDATA_I[FLD_ACT_MSB:FLD_ACT_LSB], 3))
      else $error("selector readback differs from write");

   a_ctrl_cd_write: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      apb_write && PADDR_I == ADDR_CTRL
      |=> q.act[EVT_CD] == $past(PWDATA_I[FLD_CD_LSB +: ACT_W]))
      else $error("port C down selector not written");

   a_msi_needs_code: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      rise[EVT_BD] && q.act[EVT_BD] != ACT_MSI && !q.msi_pend[EVT_BD]
      |=> !q.msi_pend[EVT_BD])
      else $error("MSI pending for a non-MSI selector");

   // Index by d: the past of q would name the previous wire
   a_intx_pin_code: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      !q.intx_req ##1 q.intx_req
      |-> q.intx_assert == $past(want[d.intx_pin]))
      else $error("legacy message level does not match routing");

   a_msi_on_set: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      rise[EVT_CU] && q.act[EVT_CU] == ACT_MSI && MSI_ENABLE_I
      ##1 MSI_ENABLE_I
      |-> q.msi_pend[EVT_CU] || (q.msi_req && q.msi_src == 2'(EVT_CU))
      || $past(q.msi_pend[EVT_CU]))
      else $error("MSI not raised on status set");

   a_msi_enable_gate: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(q.msi_req) |-> $past(MSI_ENABLE_I))
      else $error("MSI raised while disabled");

   a_intx_disable_gate: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(q.intx_req) |-> $past(!LEGACY_IRQ_DISABLE_I))
      else $error("legacy message raised while disabled");

   a_ctrl_reserved: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      apb_setup && PADDR_I == ADDR_CTRL
      |=> PRDATA_O[31:FLD_ACT_MSB+1] == '0
      && PRDATA_O[FLD_ACT_LSB-1:0] == '0)
      else $error("reserved control bits not zero");

   a_off_sends_none: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      q.act[EVT_BD] == ACT_OFF && q.act[EVT_CU] == ACT_OFF
      && q.act[EVT_CD] == ACT_OFF && q.msi_pend == '0 && !q.msi_req
      |=> q.msi_pend == '0 && !q.msi_req)
      else $error("MSI raised with every selector off");

   a_legacy_code_range: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(q.intx_req) && q.intx_assert
      |-> $past(q.act[EVT_BD] inside {[ACT_INTA:ACT_INTD]}
      || q.act[EVT_CU] inside {[ACT_INTA:ACT_INTD]}
      || q.act[EVT_CD] inside {[ACT_INTA:ACT_INTD]}))
      else $error("legacy assert without a legacy selector");

   // Host may stall; a request must not change under it
   a_msi_req_held: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      q.msi_req && !MSI_ACK_I |=> q.msi_req && $stable(q.msi_src))
      else $error("MSI request dropped before it was taken");

   a_intx_req_held: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      q.intx_req && !INTX_ACK_I
      |=> q.intx_req && $stable(q.intx_pin) && $stable(q.intx_assert))
      else $error("legacy message changed before it was taken");

   a_msi_drop_flag: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      rise[EVT_BD] && q.act[EVT_BD] == ACT_MSI && !MSI_ENABLE_I
      |=> q.evt_stat[IEV_MSI_DROP] && !q.msi_pend[EVT_BD])
      else $error("disabled MSI neither dropped nor flagged");

   a_msi_pend_gate: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      !MSI_ENABLE_I |=> q.msi_pend == '0)
      else $error("MSI held pending while disabled");

   a_intx_negate_route: assert property (
      @(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(q.intx_req) && !q.intx_assert
      |-> $past(q.intx_sent[d.intx_pin]))
      else $error("negate sent for a wire never asserted");

endmodule

// ### sim/host_msg_model.sv
`timescale 1ns/1ps
module host_msg_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] lat_i,
   input wire logic msi_req_i,
   input wire logic intx_req_i,
   output logic msi_ack_o,
   output logic intx_ack_o
);
   logic [1:0] msi_cnt_q;
   logic [1:0] intx_cnt_q;

   // Host takes a message after lat_i cycles; never acks unasked
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         msi_cnt_q <= 2'h0;
         intx_cnt_q <= 2'h0;
         msi_ack_o <= 1'b0;
         intx_ack_o <= 1'b0;
      end else begin
         msi_ack_o <= msi_req_i && !msi_ack_o && msi_cnt_q == lat_i;
         intx_ack_o <= intx_req_i && !intx_ack_o && intx_cnt_q == lat_i;
         msi_cnt_q <= (msi_req_i && !msi_ack_o) ? msi_cnt_q + 2'h1 : 2'h0;
         intx_cnt_q <= (intx_req_i && !intx_ack_o) ? intx_cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule

// ### sim/link_event_irq_action_select_tb.sv
`timescale 1ns/1ps
module link_event_irq_action_select_tb;
   import link_irq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, seen, msi_req, msi_ack, ix_req, ix_as, ix_ack;
   logic msi_en = 1'b0;
   logic lg_dis = 1'b0;
   logic irq;
   logic [NUM_EVT-1:0] evt = '0;
   logic [1:0] msi_src, ix_pin;
   logic [1:0] lat = 2'h0;
   logic [2:0] fld;
   logic [7:0] seed = 8'h3a;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   link_event_irq_action_select dut (.MCLK_I(clk), .RST_N_I(rst_n),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .EVT_STATUS_I(evt), .MSI_ENABLE_I(msi_en),
      .LEGACY_IRQ_DISABLE_I(lg_dis), .MSI_REQ_O(msi_req),
      .MSI_SRC_O(msi_src), .MSI_ACK_I(msi_ack), .INTX_REQ_O(ix_req),
      .INTX_ASSERT_O(ix_as), .INTX_PIN_O(ix_pin), .INTX_ACK_I(ix_ack),
      .IRQ_O(irq));
   host_msg_model host (.clk_i(clk), .rst_n_i(rst_n), .lat_i(lat),
      .msi_req_i(msi_req), .intx_req_i(ix_req), .msi_ack_o(msi_ack),
      .intx_ack_o(ix_ack));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [31:0] sel_word(input int e, input int c);
      return 32'(c) << (FLD_BD_LSB + ACT_W * e);
   endfunction

   task check(input string name, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Idle cycle after each transfer keeps one assignment per time step
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   // Sampled mid-cycle so the host ack cannot hide a request
   task watch(input int n);
      seen = 1'b0;
      for (int i = 0; i < n && !seen; i++) begin
         @(negedge clk);
         seen = (msi_req === 1'b1) || (ix_req === 1'b1);
         fld = (msi_req === 1'b1) ? {1'b0, msi_src} : {ix_as, ix_pin};
      end
      repeat (6) @(posedge clk);
   endtask

   task irq_is(input logic exp);
      @(negedge clk);
      check("irq", irq, exp);
      @(posedge clk);
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'hffff_ffff);
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl ones", rd, 32'h0003_fe00);
      repeat (4) begin
         seed = lfsr(seed);
         apb(1'b1, ADDR_CTRL, {4{seed}});
         apb(1'b0, ADDR_CTRL, '0);
         check("ctrl rand", rd, {4{seed}} & 32'h0003_fe00);
      end
      apb(1'b0, 12'hff0, '0);
      check("unmapped err", err, 1);
      check("unmapped data", rd, 0);
      $display("test registers done");
      msi_en <= 1'b1;
      for (int e = 0; e < NUM_EVT; e++) begin
         apb(1'b1, ADDR_CTRL, sel_word(e, ACT_MSI));
         seed = lfsr(seed);
         lat <= seed[1:0];
         evt <= 3'(1 << e);
         watch(8);
         check("msi seen", seen, 1);
         check("msi src", fld, e);
         evt <= '0;
         watch(8);
         check("msi on clear", seen, 0);
      end
      foreach (seed[i]) if (i < 3) begin
         apb(1'b1, ADDR_CTRL, sel_word(i, i == 0 ? 0 : 5 + i));
         evt <= 3'(1 << i);
         watch(8);
         check("masked code", seen, 0);
         evt <= '0;
         @(posedge clk);
      end
      $display("test msi done");
      for (int c = 2; c < 6; c++) begin
         apb(1'b1, ADDR_CTRL, sel_word(EVT_CU, c));
         evt <= 3'b010;
         watch(8);
         check("assert msg", {seen, fld}, {2'b11, 2'(c - 2)});
         evt <= '0;
         watch(8);
         check("negate msg", {seen, fld}, {2'b10, 2'(c - 2)});
      end
      apb(1'b1, ADDR_CTRL, sel_word(EVT_CD, 3));
      lg_dis <= 1'b1;
      evt <= 3'b100;
      watch(10);
      check("disabled", seen, 0);
      lg_dis <= 1'b0;
      watch(8);
      check("re-enabled", {seen, fld}, 4'b1101);
      evt <= '0;
      watch(8);
      check("re-negate", {seen, fld}, 4'b1001);
      msi_en <= 1'b0;
      apb(1'b1, ADDR_CTRL, sel_word(EVT_BD, ACT_MSI));
      evt <= 3'b001;
      watch(10);
      check("msi off", seen, 0);
      evt <= '0;
      apb(1'b0, ADDR_EVT_STAT, '0);
      check("drop bit", rd[3], 1);
      $display("test legacy done");
      apb(1'b1, ADDR_EVT_STAT, 32'hf);
      apb(1'b1, ADDR_EVT_MASK, 32'h1);
      irq_is(1'b0);
      msi_en <= 1'b1;
      evt <= 3'b001;
      watch(8);
      irq_is(1'b1);
      apb(1'b1, ADDR_EVT_MASK, 32'h0);
      irq_is(1'b0);
      apb(1'b1, ADDR_EVT_MASK, 32'h1);
      irq_is(1'b1);
      apb(1'b1, ADDR_EVT_STAT, 32'h1);
      irq_is(1'b0);
      $display("test interrupt done");
      rst_n <= 1'b0;
      @(negedge clk);
      check("reset outs", {pready, irq, msi_req, ix_req, pslverr}, 5'b10000);
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl re-reset", rd, 32'h0);
      $display("test reset done");
      stop_test;
   end
endmodule
